// ---- dsr_readout.sv ----
// dual channel converter readout: sequencing and serial result frame
// assumes host drives chip select and serial clock synchronous to i_clk
//
// Contract
// - twelve-bit result per channel each conversion
// - one conversion spans thirty-two serial clocks
// - data changes on serial clock falling edges
// - most significant bit first per channel
// - results coded as two's complement
// - channel A, four zeros, then channel B
// - frame carries the conversion in progress
// - repeat conversions while chip select low
// - three clock acquisition after chip select falls
// - both channels sampled on fourth falling edge
// - output released while chip select high
// - edges 1-4 zeros, 5-16 A, 17-20 zeros, 21-32 B
// - power-down when high; acquire, convert, power-down
// - continuous mode restarts acquisition every 32 edges
`timescale 1ns/100ps
module dsr_readout
  import dsr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic [11:0] i_channel_a_diff_input,
  input wire logic [11:0] i_channel_b_diff_input,
  output logic o_dout,
  output logic o_dout_oe_n,
  output logic o_sample,
  output logic [1:0] o_mode
);
  logic fall;
  logic cs_fall;
  logic [4:0] cnt_reg, cnt_next;
  logic run_reg, run_next;
  dsr_sample_t hold_reg, hold_next;
  dsr_mode_t mode_reg, mode_next;
  logic dout_reg, dout_next;
  logic oe_n_reg, oe_n_next;
  logic sample_reg, sample_next;
  logic [4:0] edge_idx;
  logic [11:0] cur_a;
  logic [11:0] cur_b;

  dsr_edge dsr_edge_inst (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .o_fall(fall),
    .o_cs_fall(cs_fall)
  );

  // bit of a result for a given frame position, msb first
  function automatic logic pick_bit(input logic [11:0] res, input logic [4:0] pos,
                                    input logic [4:0] first);
    logic [4:0] off;
    off = pos - first;
    pick_bit = res[4'(11 - int'(off))];
  endfunction : pick_bit

  // index of the falling edge now arriving, 0 based within the conversion
  assign edge_idx = (cs_fall || !run_reg) ? 5'h00 : cnt_reg;

  // sampled value is live at edge index 3; inputs are already two's complement codes
  assign cur_a = (edge_idx == DSR_ACQ_END) ? i_channel_a_diff_input : hold_reg.chan_a;
  assign cur_b = (edge_idx == DSR_ACQ_END) ? i_channel_b_diff_input : hold_reg.chan_b;

  always_comb begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    hold_next = hold_reg;
    mode_next = mode_reg;
    dout_next = dout_reg;
    oe_n_next = i_cs_n;
    sample_next = 1'b0;
    if (i_cs_n) begin
      run_next = 1'b0;
      cnt_next = 5'h00;
      mode_next = DSR_PWRDN;
      dout_next = 1'b0;
    end else if (fall) begin
      run_next = 1'b1;
      cnt_next = 5'(edge_idx + 5'h01);
      if (edge_idx == DSR_LAST) begin
        cnt_next = 5'h00;
      end
      if (edge_idx < DSR_ACQ_END) begin
        mode_next = DSR_ACQ;
      end else if (edge_idx == DSR_ACQ_END) begin
        mode_next = DSR_CONV;
        hold_next.chan_a = i_channel_a_diff_input;
        hold_next.chan_b = i_channel_b_diff_input;
        sample_next = 1'b1;
      end else if (edge_idx == DSR_LAST) begin
        mode_next = DSR_PWRDN;
      end
      if (edge_idx < DSR_A_FIRST) begin
        dout_next = 1'b0;
      end else if (edge_idx < DSR_B_GAP) begin
        dout_next = pick_bit(cur_a, edge_idx, DSR_A_FIRST);
      end else if (edge_idx < DSR_B_FIRST) begin
        dout_next = 1'b0;
      end else begin
        dout_next = pick_bit(cur_b, edge_idx, DSR_B_FIRST);
      end
    end else if (!run_reg) begin
      mode_next = DSR_ACQ;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_reg <= 5'h00;
      run_reg <= 1'b0;
      hold_reg <= '{chan_a: DSR_RES_RESET, chan_b: DSR_RES_RESET};
      mode_reg <= DSR_PWRDN;
      dout_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      sample_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      hold_reg <= hold_next;
      mode_reg <= mode_next;
      dout_reg <= dout_next;
      oe_n_reg <= oe_n_next;
      sample_reg <= sample_next;
    end
  end

  assign o_dout = dout_reg;
  assign o_dout_oe_n = oe_n_reg;
  assign o_sample = sample_reg;
  assign o_mode = mode_reg;

  // checks
  logic [5:0] fall_cnt;
  always_ff @(posedge i_clk) begin
    if (i_reset || i_cs_n) begin
      fall_cnt <= 6'h00;
    end else if (fall) begin
      fall_cnt <= (fall_cnt == 6'h20) ? 6'h01 : 6'(fall_cnt + 6'h01);
    end
  end

  // expected bit from frame position alone, apart from the datapath,
  // so a wrong capture or bit index in the datapath shows up here
  function automatic logic frame_bit(input logic [11:0] res_a, input logic [11:0] res_b,
                                     input logic [5:0] pos);
    logic bit_val;
    bit_val = 1'b0;
    if (pos >= 6'h04 && pos < 6'h10) begin
      bit_val = res_a[4'(6'h0F - pos)];
    end else if (pos >= 6'h14 && pos < 6'h20) begin
      bit_val = res_b[4'(6'h1F - pos)];
    end
    frame_bit = bit_val;
  endfunction : frame_bit

  logic [11:0] shadow_a_reg;
  logic [11:0] shadow_b_reg;
  logic exp_bit_reg;
  logic exp_vld_reg;

  // shadow copy of the inputs at the fourth edge
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      shadow_a_reg <= DSR_RES_RESET;
      shadow_b_reg <= DSR_RES_RESET;
    end else if (fall && fall_cnt == 6'h03) begin
      shadow_a_reg <= i_channel_a_diff_input;
      shadow_b_reg <= i_channel_b_diff_input;
    end
  end

  // expected bit stands from each edge until the next, cleared when deselected
  always_ff @(posedge i_clk) begin
    if (i_reset || i_cs_n) begin
      exp_bit_reg <= 1'b0;
      exp_vld_reg <= 1'b0;
    end else if (fall) begin
      exp_bit_reg <= frame_bit(shadow_a_reg, shadow_b_reg, fall_cnt);
      exp_vld_reg <= 1'b1;
    end
  end

  chk_oe_follows_cs: assert property (@(posedge i_clk) disable iff (i_reset)
    1'b1 |=> o_dout_oe_n == $past(i_cs_n)) else $error("output enable wrong");
  chk_sample_fourth: assert property (@(posedge i_clk) disable iff (i_reset)
    o_sample |-> $past(fall_cnt) == 6'h03) else $error("sample not on fourth edge");
  chk_leading_zero: assert property (@(posedge i_clk) disable iff (i_reset)
    (fall && !i_cs_n && fall_cnt < 6'h04) |=> !o_dout) else $error("leading bit not zero");
  chk_gap_zero: assert property (@(posedge i_clk) disable iff (i_reset)
    (fall && !i_cs_n && fall_cnt >= 6'h10 && fall_cnt < 6'h14) |=> !o_dout)
    else $error("gap bit not zero");
  chk_msb_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (fall && !i_cs_n && fall_cnt == 6'h04) |=> o_dout == hold_reg.chan_a[11])
    else $error("channel a msb wrong");
  chk_lsb_b: assert property (@(posedge i_clk) disable iff (i_reset)
    (fall && !i_cs_n && fall_cnt == 6'h1F) |=> o_dout == hold_reg.chan_b[0])
    else $error("channel b lsb wrong");
  chk_pwrdn_high: assert property (@(posedge i_clk) disable iff (i_reset)
    i_cs_n |=> o_mode == DSR_PWRDN) else $error("not powered down");
  chk_acq_mode: assert property (@(posedge i_clk) disable iff (i_reset)
    (fall && !i_cs_n && fall_cnt < 6'h03) |=> o_mode == DSR_ACQ) else $error("not acquiring");
  chk_restart: assert property (@(posedge i_clk) disable iff (i_reset)
    (fall && !i_cs_n && fall_cnt == 6'h20) |=> cnt_reg == 5'h01) else $error("no restart");
  chk_serial_bit: assert property (@(posedge i_clk) disable iff (i_reset)
    exp_vld_reg |-> o_dout == exp_bit_reg) else $error("serial bit wrong");
  chk_capture_now: assert property (@(posedge i_clk) disable iff (i_reset)
    (fall && fall_cnt == 6'h03) |=> hold_reg == {$past(i_channel_a_diff_input),
    $past(i_channel_b_diff_input)}) else $error("inputs not captured");
  chk_conv_fourth: assert property (@(posedge i_clk) disable iff (i_reset)
    (fall && fall_cnt == 6'h03) |=> o_mode == DSR_CONV) else $error("no conversion");
  chk_end_pwrdn: assert property (@(posedge i_clk) disable iff (i_reset)
    (fall && fall_cnt == 6'h1F) |=> o_mode == DSR_PWRDN) else $error("no power-down");
  chk_sample_pulse: assert property (@(posedge i_clk) disable iff (i_reset)
    o_sample |=> !o_sample) else $error("sample pulse too long");
  cov_sample: cover property (@(posedge i_clk) o_sample);
  cov_continuous: cover property (@(posedge i_clk) fall && !i_cs_n && fall_cnt == 6'h20);
  cov_abort: cover property (@(posedge i_clk) $rose(i_cs_n) && o_mode == DSR_CONV);
  cov_low_start: cover property (@(posedge i_clk) cs_fall && !i_sclk);
endmodule : dsr_readout

// ---- dsr_pkg.sv ----
// shared constants and types for the dual channel serial readout
// assumes one 250 MHz system clock; serial clock and chip select sampled as plain inputs
package dsr_pkg;
  localparam int DSR_RES_W = 12;
  localparam int DSR_FRAME_LEN = 32;
  localparam logic [4:0] DSR_ACQ_END = 5'h03;
  localparam logic [4:0] DSR_A_FIRST = 5'h04;
  localparam logic [4:0] DSR_B_GAP = 5'h10;
  localparam logic [4:0] DSR_B_FIRST = 5'h14;
  localparam logic [4:0] DSR_LAST = 5'h1F;
  localparam logic [11:0] DSR_RES_RESET = 12'h000;

  typedef enum logic [1:0] {
    DSR_PWRDN = 2'b00,
    DSR_ACQ = 2'b01,
    DSR_CONV = 2'b11
  } dsr_mode_t;

  typedef struct packed {
    logic [11:0] chan_a;
    logic [11:0] chan_b;
  } dsr_sample_t;
endpackage : dsr_pkg

// ---- dsr_edge.sv ----
// edge detector for the host serial clock and chip select
// assumes inputs already synchronous to i_clk
`timescale 1ns/100ps
module dsr_edge
  import dsr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  output logic o_fall,
  output logic o_cs_fall
);
  logic sclk_reg, sclk_next;
  logic cs_reg, cs_next;

  always_comb begin
    sclk_next = i_sclk;
    cs_next = i_cs_n;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sclk_reg <= 1'b1;
      cs_reg <= 1'b1;
    end else begin
      sclk_reg <= sclk_next;
      cs_reg <= cs_next;
    end
  end

  // a chip select fall with clock low counts as the first falling edge
  assign o_cs_fall = cs_reg & ~i_cs_n;
  assign o_fall = ~i_cs_n & ((sclk_reg & ~i_sclk) | (o_cs_fall & ~i_sclk));
endmodule : dsr_edge

// ---- dsr_host_model.sv ----
// host model: frames chip select, toggles the serial clock
// assumes it runs off the falling edge of the system clock
`timescale 1ns/100ps
module dsr_host_model
  import dsr_pkg::*;
#(parameter int HALF = 4)
(
  input wire logic i_clk,
  input wire logic i_run,
  input wire logic i_idle_low,
  output logic o_cs_n,
  output logic o_sclk
);
  int cnt = 0;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
  end
  // clock stands at its idle level between frames; low idle starts with clock low
  always @(negedge i_clk) begin
    if (!i_run) begin
      o_cs_n <= 1'b1;
      o_sclk <= ~i_idle_low;
      cnt <= 0;
    end else begin
      o_cs_n <= 1'b0;
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (!o_cs_n && cnt == HALF - 1) o_sclk <= ~o_sclk;
    end
  end
endmodule : dsr_host_model

// ---- tb_dual_adc_serial_readout.sv ----
// self-checking bench for the dual channel readout
// assumes the host model drives chip select and serial clock
`timescale 1ns/100ps
module tb_dual_adc_serial_readout;
  import dsr_pkg::*;
  logic i_clk = 1'b0, i_reset = 1'b1, run = 1'b0, idle_low = 1'b0, cs_n, sclk;
  logic [11:0] a = 12'h000, b = 12'h000;
  logic o_dout, o_dout_oe_n, o_sample;
  logic [1:0] o_mode;
  int miscompares = 0, check_count = 0, samples = 0;
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_sample === 1'b1) samples++;
  dsr_host_model dsr_host_model_inst (.i_clk(i_clk), .i_run(run), .i_idle_low(idle_low),
    .o_cs_n(cs_n), .o_sclk(sclk));
  dsr_readout dsr_readout_inst (.i_clk(i_clk), .i_reset(i_reset), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_channel_a_diff_input(a), .i_channel_b_diff_input(b), .o_dout(o_dout),
    .o_dout_oe_n(o_dout_oe_n), .o_sample(o_sample), .o_mode(o_mode));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic results();
    $display("compares %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  // bounded: a stuck clock ends the run
  task automatic wait_rise();
    int k;
    k = 0;
    while (sclk !== 1'b0 && k < 20) begin
      @(negedge i_clk);
      k++;
    end
    while (sclk !== 1'b1 && k < 20) begin
      @(negedge i_clk);
      k++;
    end
    if (k >= 20) begin
      miscompares++;
      results();
    end
  endtask : wait_rise
  // bit n sampled at the start of the high phase, after fall n
  task automatic frame(input int nb, input logic [11:0] a0, b0, a1, b1);
    logic [31:0] w;
    logic [1:0] m;
    int n;
    a = a0;
    b = b0;
    samples = 0;
    run <= 1'b1;
    for (n = 1; n <= nb; n++) begin
      wait_rise();
      w = (n > 32) ? {4'h0, a1, 4'h0, b1} : {4'h0, a0, 4'h0, b0};
      if (n == 20) begin
        a = a1;
        b = b1;
      end
      m = (n % 32 == 0) ? DSR_PWRDN : ((n % 32 < 4) ? DSR_ACQ : DSR_CONV);
      chk(32'(o_dout), 32'(w[31 - (n - 1) % 32]), "data bit");
      chk(32'(o_mode), 32'(m), "mode");
      chk(32'(o_dout_oe_n), 32'h0, "output enable");
      chk(samples, (n + 28) / 32, "sample count");
    end
    run <= 1'b0;
    repeat (3) @(negedge i_clk);
    chk(32'(o_dout_oe_n), 32'h1, "released");
    chk(32'(o_mode), 32'(DSR_PWRDN), "idle mode");
  endtask : frame
  task automatic t_single();
    frame(32, 12'h7FF, 12'h800, 12'h000, 12'h000);
    $display("test single done");
  endtask : t_single
  task automatic t_cont();
    frame(64, 12'hA5C, 12'h3C1, 12'h5A3, 12'hC3E);
    $display("test continuous done");
  endtask : t_cont
  task automatic t_abort();
    frame(10, 12'hFFF, 12'h001, 12'h000, 12'h000);
    frame(32, 12'h123, 12'h456, 12'h000, 12'h000);
    $display("test abort done");
  endtask : t_abort
  // chip select falls with clock low: that fall is edge one
  task automatic t_low_start();
    idle_low <= 1'b1;
    repeat (2) @(negedge i_clk);
    frame(32, 12'h801, 12'h7FE, 12'h000, 12'h000);
    idle_low <= 1'b0;
    repeat (2) @(negedge i_clk);
    $display("test low start done");
  endtask : t_low_start
  initial begin
    repeat (6) @(negedge i_clk);
    i_reset = 1'b0;
    repeat (2) @(negedge i_clk);
    t_single();
    t_cont();
    t_abort();
    t_low_start();
    results();
  end
endmodule : tb_dual_adc_serial_readout
